// file: rtl/fb_pkg.sv
// Constants and types of the fieldbus master
//
// How it works
// - Run indicator: off in init/firmware load, single flash preop, flashing safeop, on in op
// - Fault lamp off all exchanging, flashing if some fail, on in stop
// - Cpu lamp on for error, single flash while starting
// - Missing or faulty reply resends telegram up to retry ceiling
// - Faulty reply resends at once; missing reply waits slot time
// - Defaults: slot time 1000 bit periods, retry ceiling 4
// - Link state code 0x02 on timeout, 0x0b on faulty reply
// - Dropped slave answering wrongly: no repeat, next telegram
// - Drop-on-fault leaves polling until reconnected by at least 7 telegrams
// - Hold-until-watchdog: retry next cycle, no repeats, drop on watchdog expiry or on a good answer while connected
// - Failure zeroes or keeps inputs; link state code always nonzero
// - Faulty answer always zeroes a connected slave's input data
// - Dropped connection restored automatically or on host command
// - Dropping a connection does nothing more or forces stop
// - Auto-clear holds Clear while a selected slave has nonzero state
// - Force-stop slave failure beats auto-clear
// - Cycle tally increments after every completed cycle
package fb_pkg;

  // ********************************************************************
  // Constants
  // ********************************************************************
  localparam int          CLK_HZ          = 25_000_000;
  localparam int          NSLV            = 8;
  localparam int          SLOT_BITS_DEF   = 1000;
  localparam logic [3:0]  RETRY_DEF       = 4'h4;
  localparam logic [7:0]  ST_OK           = 8'h00;
  localparam logic [7:0]  ST_TIMEOUT      = 8'h02;
  localparam logic [7:0]  ST_FAULTY       = 8'h0b;
  localparam logic [7:0]  ST_NOCONN       = 8'h80;
  localparam int          REEST_TELEGRAMS = 7;
  localparam int          WD_MS_DEF       = 200;
  localparam int          FLASH_MS        = 200;
  localparam int          FLASH_CYC       = CLK_HZ / 1000 * FLASH_MS;

  // Register addresses
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_SLOT   = 8'h04;
  localparam logic [7:0]  A_POL    = 8'h08;
  localparam logic [7:0]  A_WD     = 8'h0c;
  localparam logic [7:0]  A_RECON  = 8'h10;
  localparam logic [7:0]  A_STAT   = 8'h14;
  localparam logic [7:0]  A_TALLY  = 8'h18;
  localparam logic [7:0]  A_STATE0 = 8'h20;
  localparam logic [7:0]  A_STATE1 = 8'h24;

  typedef enum logic [3:0] {
    ESM_INIT = 4'h1, ESM_PREOP = 4'h2, ESM_SAFEOP = 4'h4, ESM_OP = 4'h8
  } esm_t;

  typedef enum logic [2:0] {
    IND_OFF = 3'h0, IND_ON = 3'h1, IND_FLASH = 3'h2, IND_SINGLE = 3'h3
  } ind_mode_t;

  typedef struct packed {
    logic       valid;
    logic       timeout;
    logic       faulty;
  } reply_t;

  typedef struct packed {
    logic                 go;
    logic [2:0]           slave;
    logic                 connect;
  } tx_req_t;

endpackage : fb_pkg

// file: rtl/fb_indicator.sv
// Flash pattern for one status lamp
`timescale 1ns/1ps
module fb_indicator (
  input  wire logic            aclk,     // System clock
  input  wire logic            aresetn,  // Sync reset, active low
  input  wire logic            tick,     // Flash phase enable
  input  wire fb_pkg::ind_mode_t mode,   // Pattern to show
  output logic                 lamp      // Lamp drive
);
  logic [2:0] phase_r;
  logic       lamp_nxt;

  always_comb begin
    unique case (mode)
      fb_pkg::IND_ON:     lamp_nxt = 1'b1;
      fb_pkg::IND_FLASH:  lamp_nxt = phase_r[0];
      fb_pkg::IND_SINGLE: lamp_nxt = (phase_r == 3'h0);
      default:            lamp_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= 3'h0;
      lamp    <= 1'b0;
    end else begin
      if (tick) phase_r <= phase_r + 3'h1;
      lamp <= lamp_nxt;
    end
  end
endmodule : fb_indicator

// file: rtl/fb_master.sv
// Fieldbus master fault handling and register slave
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module fb_master #(
  parameter int SLOT_BITS = fb_pkg::SLOT_BITS_DEF,   // Slot time in bit periods
  parameter int BIT_CYC   = 1,                        // Clock cycles per bit period
  parameter int WD_CYC    = fb_pkg::CLK_HZ / 1000 * fb_pkg::WD_MS_DEF, // Watchdog cycles
  parameter int FLASH_CYC = fb_pkg::FLASH_CYC         // Flash phase length
) (
  input  wire logic          aclk,            // Clock
  input  wire logic          aresetn,         // Reset, active low
  input  wire logic [7:0]    s_axi_awaddr,    // Write address
  input  wire logic          s_axi_awvalid,   // Write address valid
  output logic               s_axi_awready,   // Write address ready
  input  wire logic [31:0]   s_axi_wdata,     // Write data
  input  wire logic [3:0]    s_axi_wstrb,     // Write strobes
  input  wire logic          s_axi_wvalid,    // Write data valid
  output logic               s_axi_wready,    // Write data ready
  output logic [1:0]         s_axi_bresp,     // Write response
  output logic               s_axi_bvalid,    // Write response valid
  input  wire logic          s_axi_bready,    // Write response ready
  input  wire logic [7:0]    s_axi_araddr,    // Read address
  input  wire logic          s_axi_arvalid,   // Read address valid
  output logic               s_axi_arready,   // Read address ready
  output logic [31:0]        s_axi_rdata,     // Read data
  output logic [1:0]         s_axi_rresp,     // Read response
  output logic               s_axi_rvalid,    // Read data valid
  input  wire logic          s_axi_rready,    // Read ready
  input  wire fb_pkg::esm_t  net_state,       // Host network state
  input  wire logic          cpu_err,         // Processor error
  input  wire logic          cpu_boot,        // Processor starting
  output fb_pkg::tx_req_t    tx_req,          // Telegram request pulse
  input  wire fb_pkg::reply_t rx_reply,       // Reply outcome pulse
  input  wire logic [31:0]   rx_data,         // Received input data
  output logic [31:0]        in_data,         // Input data
  output logic [2:0]         in_slave,        // Slave for in_data
  output logic               in_valid,        // in_data strobe
  output logic               clear_mode,      // Master in Clear
  output logic               stop_mode,       // Master in STOP
  output logic               run_led,         // Run indicator
  output logic               bus_fault_indicator, // Bus fault indicator
  output logic               cpu_err_led      // Processor error indicator
);
  localparam int N = fb_pkg::NSLV;

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [31:0] ctrl_r;      // [3:0] retry, [4] auto-clear, [5] all slaves, [6] enable
  logic [31:0] pol_r;       // per slave: [n] hold_until_watchdog, [8+n] keep inputs,
                            // [16+n] manual restart, [24+n] force stop
  logic [7:0]  mc_r;        // motion-control slave mask in ctrl_r[15:8]
  logic [15:0] slot_r;
  logic [31:0] tally_r;
  logic [7:0]  slave_link_state [N];
  logic [7:0]  recon_req_r;
  logic        stop_r;

  wire [3:0] retry_max = ctrl_r[3:0];
  wire       auto_clr  = ctrl_r[4];
  wire       clr_all   = ctrl_r[5];
  wire       poll_en   = ctrl_r[6];

  // ********************************************************************
  // AXI4-Lite slave
  // ********************************************************************
  logic       aw_have_r, w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  wire        wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  wire        aw_ok = s_axi_awvalid && s_axi_awready;
  wire        w_ok  = s_axi_wvalid && s_axi_wready;
  wire        ar_ok = s_axi_arvalid && s_axi_arready;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      fb_pkg::A_CTRL:   v = ctrl_r;
      fb_pkg::A_SLOT:   v = {16'h0, slot_r};
      fb_pkg::A_POL:    v = pol_r;
      fb_pkg::A_STAT:   v = {29'h0, cpu_err, stop_r, clear_mode};
      fb_pkg::A_TALLY:  v = tally_r;
      fb_pkg::A_STATE0: v = {slave_link_state[3], slave_link_state[2],
                             slave_link_state[1], slave_link_state[0]};
      fb_pkg::A_STATE1: v = {slave_link_state[7], slave_link_state[6],
                             slave_link_state[5], slave_link_state[4]};
      default:          v = 32'h0;
    endcase
    return v;
  endfunction : rd_mux

  function automatic logic known(input logic [7:0] a);
    return (a == fb_pkg::A_CTRL) || (a == fb_pkg::A_SLOT) || (a == fb_pkg::A_POL) ||
           (a == fb_pkg::A_RECON) || (a == fb_pkg::A_STAT) || (a == fb_pkg::A_TALLY) ||
           (a == fb_pkg::A_STATE0) || (a == fb_pkg::A_STATE1);
  endfunction : known

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;  w_have_r <= 1'b0;
      aw_addr_r <= 8'h00; w_data_r <= 32'h0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0; s_axi_rresp <= 2'h0; s_axi_rdata <= 32'h0;
    end else begin
      s_axi_awready <= !aw_have_r && !aw_ok;
      s_axi_wready  <= !w_have_r && !w_ok;
      if (aw_ok) begin aw_have_r <= 1'b1; aw_addr_r <= s_axi_awaddr; end
      if (w_ok)  begin w_have_r <= 1'b1;  w_data_r <= s_axi_wdata; end
      if (wr_go) begin
        aw_have_r <= 1'b0; w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(aw_addr_r) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_rvalid && !ar_ok;
      if (ar_ok) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux(s_axi_araddr);
        s_axi_rresp  <= known(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  wire wr_ctrl  = wr_go && aw_addr_r == fb_pkg::A_CTRL;
  wire wr_slot  = wr_go && aw_addr_r == fb_pkg::A_SLOT;
  wire wr_pol   = wr_go && aw_addr_r == fb_pkg::A_POL;
  wire wr_recon = wr_go && aw_addr_r == fb_pkg::A_RECON;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // default retry ceiling and slot time
      ctrl_r <= {24'h0, 4'h0, fb_pkg::RETRY_DEF};
      slot_r <= 16'(SLOT_BITS);
      pol_r  <= 32'h0;
    end else begin
      if (wr_ctrl && s_axi_wstrb[0]) ctrl_r[7:0]  <= w_data_r[7:0];
      if (wr_ctrl && s_axi_wstrb[1]) ctrl_r[15:8] <= w_data_r[15:8];
      if (wr_slot) slot_r <= w_data_r[15:0];
      if (wr_pol)  pol_r  <= w_data_r;
    end
  end
  assign mc_r = ctrl_r[15:8];

  // ********************************************************************
  // Polling engine
  // ********************************************************************
  typedef enum logic [3:0] {
    P_IDLE = 4'h1, P_SEND = 4'h2, P_WAIT = 4'h4, P_NEXT = 4'h8
  } poll_t;
  poll_t       ps_r;
  logic [2:0]  cur_r;
  logic [3:0]  tries_r;
  logic [31:0] tmo_r;
  logic [2:0]  reest_r [N];
  logic [31:0] wd_r [N];
  logic [7:0]  conn_r, inpoll_r;

  wire        cur_conn  = conn_r[cur_r];
  wire        cur_hold  = pol_r[cur_r];
  wire        cur_keep  = pol_r[8 + cur_r];
  wire        cur_man   = pol_r[16 + cur_r];
  wire        cur_stop  = pol_r[24 + cur_r];
  wire [31:0] slot_cyc  = 32'(slot_r) * 32'(BIT_CYC);
  wire        tmo_hit   = (ps_r == P_WAIT) && (tmo_r == 32'h1) && !rx_reply.valid;
  wire        bad_ans   = (ps_r == P_WAIT) && rx_reply.valid && rx_reply.faulty;
  wire        good_ans  = (ps_r == P_WAIT) && rx_reply.valid && !rx_reply.faulty;
  wire        fail_ev   = tmo_hit || bad_ans;
  wire        may_retry = cur_conn && !cur_hold && (tries_r < retry_max);
  wire        last_slv  = (cur_r == 3'(N - 1));
  wire        drop_now  = fail_ev && cur_conn && !may_retry && !cur_hold;
  wire        wd_drop   = cur_conn && cur_hold && (wd_r[cur_r] == 32'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_r <= P_IDLE; cur_r <= 3'h0; tries_r <= 4'h0; tmo_r <= 32'h0;
      tally_r <= 32'h0; stop_r <= 1'b0; conn_r <= 8'h00; inpoll_r <= 8'hff;
      tx_req <= '0; in_valid <= 1'b0; in_data <= 32'h0; in_slave <= 3'h0;
      recon_req_r <= 8'h00;
      for (int i = 0; i < N; i++) begin
        slave_link_state[i] <= fb_pkg::ST_NOCONN;
        reest_r[i] <= 3'h0;
        wd_r[i] <= 32'h0;
      end
    end else begin
      tx_req.go <= 1'b0;
      in_valid  <= 1'b0;
      if (wr_recon) recon_req_r <= recon_req_r | w_data_r[7:0];
      unique case (ps_r)
        P_IDLE: if (poll_en && !stop_r) begin
          cur_r <= 3'h0; tries_r <= 4'h0; ps_r <= P_SEND;
        end
        P_SEND: begin
          if (!inpoll_r[cur_r] || stop_r) ps_r <= P_NEXT;
          else begin
            tx_req <= '{go: 1'b1, slave: cur_r, connect: !cur_conn};
            tmo_r  <= slot_cyc;
            ps_r   <= P_WAIT;
          end
        end
        P_WAIT: begin
          if (tmo_r != 32'h0) tmo_r <= tmo_r - 32'h1;
          if (good_ans) begin
            if (cur_conn) begin
              slave_link_state[cur_r] <= fb_pkg::ST_OK;
              wd_r[cur_r] <= 32'(WD_CYC);
              in_data <= rx_data; in_slave <= cur_r; in_valid <= 1'b1;
            end else if (reest_r[cur_r] == 3'(fb_pkg::REEST_TELEGRAMS - 1)) begin
              conn_r[cur_r] <= 1'b1; reest_r[cur_r] <= 3'h0;
              slave_link_state[cur_r] <= fb_pkg::ST_OK;
              wd_r[cur_r] <= 32'(WD_CYC);
            end else reest_r[cur_r] <= reest_r[cur_r] + 3'h1;
            ps_r <= P_NEXT;
          end else if (fail_ev) begin
            if (cur_conn)
              slave_link_state[cur_r] <= tmo_hit ? fb_pkg::ST_TIMEOUT : fb_pkg::ST_FAULTY;
            if (cur_conn && (bad_ans || !cur_keep)) begin
              in_data <= 32'h0; in_slave <= cur_r; in_valid <= 1'b1;
            end
            if (!cur_conn) reest_r[cur_r] <= 3'h0;
            if (may_retry) begin
              tries_r <= tries_r + 4'h1; ps_r <= P_SEND;
            end else ps_r <= P_NEXT;
            if (drop_now) begin
              conn_r[cur_r] <= 1'b0; inpoll_r[cur_r] <= 1'b0;
              if (cur_stop) stop_r <= 1'b1;
            end
          end
        end
        P_NEXT: begin
          tries_r <= 4'h0;
          if (last_slv) begin
            tally_r <= tally_r + 32'h1;
            ps_r <= P_IDLE;
          end else begin
            cur_r <= cur_r + 3'h1; ps_r <= P_SEND;
          end
        end
        default: ps_r <= P_IDLE;
      endcase
      for (int i = 0; i < N; i++) begin
        if (wd_r[i] != 32'h0 && !(good_ans && cur_r == 3'(i))) wd_r[i] <= wd_r[i] - 32'h1;
        else if (conn_r[i] && pol_r[i]) begin
          conn_r[i] <= 1'b0; inpoll_r[i] <= 1'b0;
          if (pol_r[24 + i]) stop_r <= 1'b1;
        end
        if (!inpoll_r[i] && !stop_r && (!pol_r[16 + i] || recon_req_r[i])) begin
          inpoll_r[i] <= 1'b1; recon_req_r[i] <= 1'b0;
        end
      end
      if (stop_r) begin
        conn_r <= 8'h00;
        for (int i = 0; i < N; i++) slave_link_state[i] <= fb_pkg::ST_NOCONN;
        if (wr_ctrl && w_data_r[7]) stop_r <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Clear state and indicators
  // ********************************************************************
  logic [7:0] bad_vec, clr_vec;
  for (genvar g = 0; g < N; g++) begin : g_bad
    assign bad_vec[g] = (slave_link_state[g] != fb_pkg::ST_OK);
    assign clr_vec[g] = bad_vec[g] && (clr_all || mc_r[g]);
  end

  logic tick_r;
  logic [31:0] fcnt_r;
  fb_pkg::ind_mode_t run_mode, bf_mode, cpu_mode;
  assign run_mode = (net_state == fb_pkg::ESM_OP)     ? fb_pkg::IND_ON :
                    (net_state == fb_pkg::ESM_SAFEOP) ? fb_pkg::IND_FLASH :
                    (net_state == fb_pkg::ESM_PREOP)  ? fb_pkg::IND_SINGLE : fb_pkg::IND_OFF;
  assign bf_mode  = stop_r ? fb_pkg::IND_ON : (|bad_vec) ? fb_pkg::IND_FLASH : fb_pkg::IND_OFF;
  assign cpu_mode = cpu_err ? fb_pkg::IND_ON : cpu_boot ? fb_pkg::IND_SINGLE : fb_pkg::IND_OFF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcnt_r <= 32'h0; tick_r <= 1'b0; clear_mode <= 1'b1; stop_mode <= 1'b0;
    end else begin
      tick_r <= (fcnt_r == 32'(FLASH_CYC - 1));
      fcnt_r <= (fcnt_r == 32'(FLASH_CYC - 1)) ? 32'h0 : fcnt_r + 32'h1;
      clear_mode <= !stop_r && auto_clr && (|clr_vec);
      stop_mode  <= stop_r;
    end
  end

  fb_indicator u_run (.aclk(aclk), .aresetn(aresetn), .tick(tick_r), .mode(run_mode), .lamp(run_led));
  fb_indicator u_bf  (.aclk(aclk), .aresetn(aresetn), .tick(tick_r), .mode(bf_mode),
                      .lamp(bus_fault_indicator));
  fb_indicator u_cpu (.aclk(aclk), .aresetn(aresetn), .tick(tick_r), .mode(cpu_mode), .lamp(cpu_err_led));

endmodule : fb_master

// file: verif/fb_master_monitor.sv
// Port assertions for the fieldbus master
`timescale 1ns/1ps
module fb_master_monitor (
  input wire logic            aclk,                // Clock
  input wire logic            aresetn,             // Reset, low
  input wire logic            s_axi_bvalid,        // Write resp valid
  input wire logic            s_axi_bready,        // Write resp ready
  input wire logic            s_axi_rvalid,        // Read valid
  input wire logic            s_axi_rready,        // Read ready
  input wire logic [31:0]     s_axi_rdata,         // Read data
  input wire fb_pkg::esm_t    net_state,           // Host state
  input wire logic            cpu_err,             // Cpu error
  input wire logic            cpu_boot,            // Cpu start
  input wire fb_pkg::tx_req_t tx_req,              // Telegram request
  input wire fb_pkg::reply_t  rx_reply,            // Reply
  input wire logic            in_valid,            // Input strobe
  input wire logic [31:0]     in_data,             // Input data
  input wire logic            stop_mode,           // Stop
  input wire logic            run_led,             // Run lamp
  input wire logic            bus_fault_indicator, // Fault lamp
  input wire logic            cpu_err_led          // Cpu lamp
);
  // ****************************************
  // Helpers and checks
  // ****************************************
  // Smallest slot programmed, one cycle per bit
  localparam int SLOT_MIN = 16;
  logic [7:0] gap_r;
  logic       replied_r;
  logic       seen_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r     <= 8'h00;
      replied_r <= 1'b0;
      seen_r    <= 1'b0;
    end else begin
      gap_r     <= tx_req.go ? 8'h01 : (gap_r == 8'hff ? gap_r : gap_r + 8'h01);
      replied_r <= !tx_req.go && (replied_r || rx_reply.valid);
      seen_r    <= seen_r || tx_req.go;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence faulty_rx;
    rx_reply.valid && rx_reply.faulty;
  endsequence
  sequence op_held;
    (net_state == fb_pkg::ESM_OP)[*4];
  endsequence
  chk_go_single: assert property (tx_req.go |=> !tx_req.go)
    else $error("go held over one cycle");
  chk_retry_waits: assert property (tx_req.go && seen_r && !replied_r |-> gap_r >= SLOT_MIN)
    else $error("resend before slot time");
  chk_faulty_zeroes: assert property (faulty_rx |=> (!in_valid || in_data == 32'h0)[*3])
    else $error("faulty answer gave nonzero inputs");
  chk_run_on_op: assert property (op_held |-> run_led)
    else $error("run lamp off in op");
  chk_run_off_init: assert property ((net_state == fb_pkg::ESM_INIT)[*4] |-> !run_led)
    else $error("run lamp lit in init");
  chk_cpu_err_lamp: assert property ((cpu_err && !cpu_boot)[*4] |-> cpu_err_led)
    else $error("cpu lamp dark");
  chk_stop_lamp_on: assert property (stop_mode[*4] |-> bus_fault_indicator)
    else $error("fault lamp dark in stop");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped early");
endmodule : fb_master_monitor

bind fb_master fb_master_monitor i_mon (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .net_state, .cpu_err, .cpu_boot, .tx_req, .rx_reply, .in_valid, .in_data,
  .stop_mode, .run_led, .bus_fault_indicator, .cpu_err_led);

// file: verif/fb_slave_model.sv
// Model of the fieldbus slaves
`timescale 1ns/1ps
module fb_slave_model (
  input  wire logic            aclk,     // Clock
  input  wire logic            aresetn,  // Reset, low
  input  wire fb_pkg::tx_req_t tx_req,   // Telegram request
  input  wire logic [7:0]      silent,   // Slaves not answering
  input  wire logic [7:0]      faulty,   // Slaves answering badly
  input  wire logic [3:0]      lat,      // Answer delay
  input  wire logic [31:0]     pdata,    // Input data to return
  input  wire logic            cnt_clr,  // Clear tallies
  output fb_pkg::reply_t       rx_reply, // Reply pulse
  output logic [31:0]          rx_data   // Reply data
);
  int         data_cnt [8];
  int         conn_cnt [8];
  int         rep_cnt;
  logic [2:0] last_s;
  logic [2:0] slv;
  logic [3:0] wait_r;
  logic       pend;
  // reply after lat cycles, prompt or slow
  always @(posedge aclk) begin
    rx_reply <= '0;
    // Idle data toggles so stale data never looks valid
    rx_data  <= aresetn ? ~rx_data : 32'h5a5a_a5a5;
    if (!aresetn) pend <= 1'b0;
    else if (tx_req.go) begin
      pend   <= !silent[tx_req.slave];
      slv    <= tx_req.slave;
      wait_r <= lat;
    end else if (pend && wait_r != 4'h0) wait_r <= wait_r - 4'h1;
    else if (pend) begin
      pend     <= 1'b0;
      rx_reply <= '{valid: 1'b1, timeout: 1'b0, faulty: faulty[slv]};
      rx_data  <= pdata;
    end
  end
  always @(posedge aclk) begin
    if (cnt_clr) begin
      foreach (data_cnt[i]) begin
        data_cnt[i] = 0;
        conn_cnt[i] = 0;
      end
      rep_cnt = 0;
    end else if (tx_req.go && tx_req.connect) conn_cnt[tx_req.slave]++;
    else if (tx_req.go) begin
      if (tx_req.slave == last_s) rep_cnt++;
      data_cnt[tx_req.slave]++;
      last_s = tx_req.slave;
    end
  end
endmodule : fb_slave_model

// file: verif/tb_fb_master.sv
// Bench for the fieldbus master
`timescale 1ns/1ps
module tb_fb_master;
  typedef struct {logic [1:0] r; logic [31:0] d; logic [31:0] m;} exp_t;
  exp_t q[$];
  int n_errors = 0, checked = 0, cyc = 0;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awr, wrdy, bv, arr, rv, clear_mode, stop_mode, cpu_err = 0, cpu_boot = 0, cnt_clr = 1;
  logic [1:0] bresp, rresp;
  logic [7:0] aa = 8'h00, ar = 8'h00, silent = 8'h00, faulty = 8'h00;
  logic [3:0] lat = 4'h1;
  logic [31:0] wd = 32'h0, rd_d, rx_data, pdata = 32'h8;
  fb_pkg::esm_t net_state = fb_pkg::ESM_INIT;
  fb_pkg::tx_req_t tx_req;
  fb_pkg::reply_t rx_reply;
  fb_master #(.SLOT_BITS(1000), .BIT_CYC(1), .WD_CYC(2000), .FLASH_CYC(4)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .net_state, .cpu_err, .cpu_boot,
    .tx_req, .rx_reply, .rx_data, .in_data(), .in_slave(), .in_valid(), .clear_mode, .stop_mode,
    .run_led(), .bus_fault_indicator(), .cpu_err_led());
  fb_slave_model i_slv (.aclk, .aresetn, .tx_req, .silent, .faulty, .lat, .pdata, .cnt_clr, .rx_reply,
    .rx_data);
  // ****************************************
  // Clock and tasks
  // ****************************************
  initial forever #20 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  always @(posedge aclk) pdata <= lfsr(pdata);
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  always @(posedge aclk) begin : mon
    exp_t e;
    if ((bv && bready) || (rv && rready)) begin
      e = q.pop_front();
      cmp({30'h0, bv ? bresp : rresp}, {30'h0, e.r});
      if (rv) cmp(rd_d & e.m, e.d & e.m);
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic da, dw, ok;
    q.push_back('{r, 32'h0, 32'h0});
    @(posedge aclk);
    aa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; da = 0; dw = 0;
    while (!(da && dw)) begin
      @(negedge aclk);
      da = da || awr;
      dw = dw || wrdy;
      @(posedge aclk);
      if (da) awv <= 1'b0;
      if (dw) wv <= 1'b0;
    end
    bready <= 1'b1;
    do begin @(negedge aclk); ok = bv; @(posedge aclk); end while (!ok);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r, output logic [31:0] d);
    logic ok;
    q.push_back('{r, e, m});
    @(posedge aclk);
    ar <= a; arv <= 1'b1;
    do begin @(negedge aclk); ok = arr; @(posedge aclk); end while (!ok);
    arv <= 1'b0; rready <= 1'b1;
    do begin @(negedge aclk); ok = rv; d = rd_d; @(posedge aclk); end while (!ok);
    rready <= 1'b0;
  endtask : rd
  task automatic arm(input logic [7:0] s, f, input logic [3:0] l, input int n);
    @(posedge aclk);
    silent <= s; faulty <= f; lat <= l; cnt_clr <= 1'b1;
    @(posedge aclk);
    cnt_clr <= 1'b0;
    repeat (n) @(posedge aclk);
  endtask : arm
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d1, d2;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      net_state <= fb_pkg::esm_t'(4'h1 << i);
      cpu_boot <= (i == 1);
      cpu_err <= (i == 3);
      repeat (12) @(posedge aclk);
    end
    $display("indicators done");
    rd(fb_pkg::A_CTRL, 32'h4, 32'hf, 2'h0, d1);
    rd(fb_pkg::A_SLOT, 32'h3e8, 32'hffff_ffff, 2'h0, d1);
    rd(8'h40, 32'h0, 32'h0, 2'h2, d1);
    wr(8'h44, 32'h1, 2'h2);
    wr(fb_pkg::A_SLOT, 32'h10, 2'h0);
    wr(fb_pkg::A_POL, 32'h0028_0000, 2'h0);
    wr(fb_pkg::A_CTRL, 32'h44, 2'h0);
    rd(fb_pkg::A_TALLY, 32'h0, 32'h0, 2'h0, d1);
    repeat (500) @(posedge aclk);
    rd(fb_pkg::A_TALLY, 32'h0, 32'h0, 2'h0, d2);
    cmp(32'(d2 > d1), 32'h1);
    $display("registers done");
    arm(8'h08, 8'h20, 4'h1, 600);
    cmp(i_slv.data_cnt[3], 32'h5);
    cmp(i_slv.data_cnt[5], 32'h5);
    rd(fb_pkg::A_STATE0, 32'h0200_0000, 32'hff00_0000, 2'h0, d1);
    rd(fb_pkg::A_STATE1, 32'h0000_0b00, 32'h0000_ff00, 2'h0, d1);
    arm(8'h00, 8'h00, 4'h9, 200);
    cmp(i_slv.conn_cnt[3], 32'h0);
    wr(fb_pkg::A_RECON, 32'h28, 2'h0);
    repeat (1000) @(posedge aclk);
    cmp(32'(i_slv.conn_cnt[3] >= 7), 32'h1);
    rd(fb_pkg::A_STATE0, 32'h0, 32'hff00_0000, 2'h0, d1);
    $display("failure done");
    wr(fb_pkg::A_POL, 32'h08, 2'h0);
    wr(fb_pkg::A_CTRL, 32'h40, 2'h0);
    arm(8'h08, 8'h00, 4'h1, 300);
    cmp(32'(i_slv.data_cnt[3] > 1), 32'h1);
    cmp(i_slv.rep_cnt, 32'h0);
    repeat (2300) @(posedge aclk);
    arm(8'h08, 8'h00, 4'h1, 300);
    cmp(i_slv.data_cnt[3], 32'h0);
    $display("hold done");
    wr(fb_pkg::A_POL, 32'h0, 2'h0);
    wr(fb_pkg::A_CTRL, 32'h74, 2'h0);
    arm(8'h04, 8'h00, 4'h1, 300);
    cmp(32'(clear_mode), 32'h1);
    rd(fb_pkg::A_STAT, 32'h1, 32'h1, 2'h0, d1);
    arm(8'h00, 8'h00, 4'h1, 800);
    cmp(32'(clear_mode), 32'h0);
    wr(fb_pkg::A_POL, 32'h4000_0000, 2'h0);
    arm(8'h40, 8'h00, 4'h1, 400);
    cmp(32'(stop_mode), 32'h1);
    cmp(32'(clear_mode), 32'h0);
    rd(fb_pkg::A_STAT, 32'h2, 32'h3, 2'h0, d1);
    arm(8'h00, 8'h00, 4'h1, 0);
    wr(fb_pkg::A_POL, 32'h0, 2'h0);
    wr(fb_pkg::A_CTRL, 32'hf4, 2'h0);
    repeat (800) @(posedge aclk);
    cmp(32'(stop_mode), 32'h0);
    $display("master reactions done");
    report_and_stop();
  end
endmodule : tb_fb_master
